// [hdl/svm_ctrl.sv]
// supply voltage monitor control: mode bits, conversion timing, result, low-voltage reset
// What this block does
// - mode bits select off, quarter-hertz or continuous
// - status bit reads busy during conversion
// - oscillator stop waits for running conversion
// - sleep wait clears both mode bits
// - four-bit result held until next conversion
// - result changes only at conversion end
// - conversion tick aligned, sixteen ticks long
// - continuous conversions run back to back
// - continuous off finishes conversion, reads busy
// - auto mode converts once every four seconds
// - auto off finishes running conversion first
// - auto mode busy only inside conversion
// - four level-zero results force continuous, reset
// - low-voltage reset holds until level two
// - reset release restores previous sampling mode
// - first conversion after reset, busy meanwhile
// - first result comes from first conversion
// - reset and sleep clear both mode bits
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module svm_ctrl
  import svm_pkg::*;
#(
  parameter int TICK_CYCLES = SVM_TICK_CYCLES,
  parameter int AUTO_TICKS = SVM_AUTO_TICKS,
  parameter bit LVR_OPTION = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SVM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instruction,
  input wire logic cmp_above,
  output logic [3:0] sar_trial,
  output logic sampling_active,
  output logic osc_stop_grant,
  output logic lv_reset,
  output logic [3:0] level_result
);

  // one step of successive approximation at bit position idx
  function automatic logic [3:0] sar_step(input logic [3:0] trial, input logic [1:0] idx,
                                          input logic above);
    logic [3:0] t;
    t = trial;
    t[idx] = above;
    if (idx != 2'd0) begin
      t[idx - 2'd1] = 1'b1;
    end
    return t;
  endfunction : sar_step

  svm_state_e state;
  logic cmp_meta;
  logic cmp_sync;
  logic [$clog2(TICK_CYCLES)-1:0] tick_div;
  logic tick;
  logic [$clog2(AUTO_TICKS)-1:0] auto_cnt;
  logic [3:0] conv_cnt;
  logic cont_ctl;
  logic auto_ctl;
  logic first_pending;
  logic sleep_wait;
  logic lvr_active;
  logic saved_cont;
  logic saved_auto;
  logic [2:0] zero_run;
  logic busy;
  logic status;
  logic addr_hit;
  logic wr_evt;
  logic auto_due;
  logic start_req;
  logic end_evt;
  logic [1:0] bit_idx;
  logic [3:0] next_trial;
  logic [3:0] next_level;
  logic lvr_set;
  logic lvr_clr;
  logic conv_next;
  logic [$clog2(SVM_CONV_TICKS * TICK_CYCLES)-1:0] conv_cycles;

  // comparator arrives from the analog side, so synchronise it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= cmp_above;
      cmp_sync <= cmp_meta;
    end
  end

  // common divider chain: 2048 Hz tick, then the four second interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_div == ($bits(tick_div))'(TICK_CYCLES - 1));
      if (tick_div == ($bits(tick_div))'(TICK_CYCLES - 1)) begin
        tick_div <= '0;
      end else begin
        tick_div <= tick_div + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_cnt <= '0;
    end else if (tick) begin
      if (auto_cnt == ($bits(auto_cnt))'(AUTO_TICKS - 1)) begin
        auto_cnt <= '0;
      end else begin
        auto_cnt <= auto_cnt + 1'b1;
      end
    end
  end

  assign busy = (state == SVM_ST_CONV);
  // a cleared continuous bit still reads 1 until the conversion ends
  assign status = cont_ctl | busy | first_pending;
  assign addr_hit = (paddr == SVM_CTRL_RESULT_ADDR);
  assign wr_evt = psel & penable & pready & pwrite & addr_hit & ~lvr_active;
  assign auto_due = auto_ctl & (auto_cnt == '0);
  // continuous wins over auto whatever the auto bit holds
  assign start_req = tick & (cont_ctl | auto_due | first_pending | lvr_active);
  assign end_evt = tick & busy & (conv_cnt == SVM_CONV_LAST);
  assign bit_idx = 2'd3 - conv_cnt[3:2];
  assign next_trial = sar_step(sar_trial, bit_idx, cmp_sync);
  assign next_level = next_trial;
  assign lvr_set = LVR_OPTION & end_evt & ~lvr_active & (next_level == SVM_LEVEL_ZERO)
                   & (zero_run == SVM_ZERO_RUN - 3'd1);
  assign lvr_clr = lvr_active & end_evt & (next_level >= SVM_LEVEL_RELEASE);
  // busy in the next cycle; also gates the oscillator stop
  assign conv_next = busy ? !(end_evt && !(cont_ctl || lvr_active || lvr_set)) : start_req;

  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SVM_ST_IDLE;
      conv_cnt <= '0;
    end else begin
      case (state)
        SVM_ST_IDLE: begin
          if (start_req) begin
            state <= SVM_ST_CONV;
            conv_cnt <= '0;
          end
        end
        SVM_ST_CONV: begin
          if (tick) begin
            conv_cnt <= conv_cnt + 1'b1;
          end
          // end tick doubles as next start tick so no gap appears
          if (end_evt && !(cont_ctl || lvr_active || lvr_set)) begin
            state <= SVM_ST_IDLE;
          end
        end
        default: begin
          state <= SVM_ST_IDLE;
        end
      endcase
    end
  end

  // cycles inside the running conversion, counted apart from conv_cnt for checking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cycles <= '0;
    end else if ((state == SVM_ST_IDLE && start_req) || end_evt) begin
      conv_cycles <= '0;
    end else if (busy) begin
      conv_cycles <= conv_cycles + 1'b1;
    end
  end

  // successive approximation trial word and result latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_trial <= 4'h8;
    end else if ((state == SVM_ST_IDLE && start_req) || end_evt) begin
      sar_trial <= 4'h8;
    end else if (busy && tick && conv_cnt[1:0] == 2'b11) begin
      sar_trial <= next_trial;
    end
  end

  // undefined until the first conversion; reset value only keeps sim clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_result <= SVM_LEVEL_RST;
    end else if (end_evt) begin
      level_result <= next_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pending <= 1'b1;
    end else if (end_evt) begin
      first_pending <= 1'b0;
    end
  end

  // mode bits: sleep clear beats everything, then low-voltage override, then software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_ctl <= SVM_CONT_RST;
      auto_ctl <= SVM_AUTO_RST;
    end else if (sleep_instruction) begin
      cont_ctl <= 1'b0;
      auto_ctl <= 1'b0;
    end else if (lvr_set) begin
      cont_ctl <= 1'b1;
      auto_ctl <= auto_ctl;
    end else if (lvr_clr) begin
      cont_ctl <= saved_cont;
      auto_ctl <= saved_auto;
    end else if (wr_evt) begin
      cont_ctl <= pwdata[SVM_CONT_BIT];
      auto_ctl <= pwdata[SVM_AUTO_BIT];
    end
  end

  // low-voltage reset detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_run <= '0;
      lvr_active <= 1'b0;
      saved_cont <= 1'b0;
      saved_auto <= 1'b0;
    end else begin
      if (end_evt) begin
        if (next_level != SVM_LEVEL_ZERO) begin
          zero_run <= '0;
        end else if (zero_run != SVM_ZERO_RUN) begin
          zero_run <= zero_run + 3'd1;
        end
      end
      if (lvr_set) begin
        lvr_active <= 1'b1;
        saved_cont <= cont_ctl;
        saved_auto <= auto_ctl;
      end else if (lvr_clr) begin
        lvr_active <= 1'b0;
      end
    end
  end

  // sleep: hold off the oscillator stop while a conversion runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_wait <= 1'b0;
      osc_stop_grant <= 1'b0;
    end else begin
      // a sleep on a start tick or a final tick waits for whatever still runs
      osc_stop_grant <= (sleep_instruction || sleep_wait) && !conv_next;
      sleep_wait <= (sleep_instruction || sleep_wait) && conv_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampling_active <= 1'b0;
      lv_reset <= 1'b0;
    end else begin
      sampling_active <= conv_next;
      lv_reset <= lvr_set | (lvr_active & ~lvr_clr);
    end
  end

  // apb slave, one wait state; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_hit;
      if (psel && penable && !pready && !pwrite && addr_hit) begin
        prdata <= {26'h0, auto_ctl, status, level_result};
      end else begin
        prdata <= '0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_conv_end;
    end_evt;
  endsequence

  sequence s_ready_read;
    pready && !pwrite && !pslverr;
  endsequence

  a_mode_off_idle: assert property (
    (state == SVM_ST_IDLE) && !cont_ctl && !auto_ctl && !first_pending && !lvr_active
    |=> state == SVM_ST_IDLE)
    else $error("monitor left idle with both mode bits clear");

  a_status_read_busy: assert property (
    s_ready_read |-> prdata[SVM_CONT_BIT] == $past(status))
    else $error("status bit read does not match busy state");

  a_sleep_no_stop: assert property (
    sleep_wait && !end_evt |=> !osc_stop_grant)
    else $error("oscillator stop granted during conversion");

  a_sleep_clears_mode: assert property (
    sleep_instruction |=> !cont_ctl && !auto_ctl)
    else $error("mode bits not cleared on sleep");

  a_result_held: assert property (
    !end_evt |=> $stable(level_result))
    else $error("result changed outside conversion end");

  a_conv_sixteen: assert property (
    s_conv_end |-> conv_cycles == ($bits(conv_cycles))'(SVM_CONV_TICKS * TICK_CYCLES - 1))
    else $error("conversion length not sixteen ticks");

  a_back_to_back: assert property (
    s_conv_end ##0 (cont_ctl && !sleep_instruction) |=> busy && conv_cnt == 4'd0)
    else $error("gap between continuous conversions");

  a_lvr_assert: assert property (
    lvr_set |=> lv_reset && cont_ctl)
    else $error("low-voltage reset not raised");

  a_lvr_hold: assert property (
    lv_reset && !lvr_clr |=> lv_reset)
    else $error("low-voltage reset dropped early");

  a_first_busy: assert property (
    first_pending && tick && !end_evt |=> sampling_active && status)
    else $error("busy not shown before first conversion");

  a_tick_aligned: assert property (
    $rose(busy) |-> $past(tick))
    else $error("conversion started off the tick");

  a_auto_start: assert property (
    $rose(busy) && !$past(cont_ctl) && !$past(first_pending) && !$past(lvr_active)
    |-> $past(auto_cnt) == '0)
    else $error("auto conversion started off the interval");

  a_stop_idle: assert property (
    osc_stop_grant |-> !busy)
    else $error("oscillator stop granted while converting");

  a_lvr_release: assert property (
    lvr_clr && !sleep_instruction |=> cont_ctl == $past(saved_cont) && auto_ctl == $past(saved_auto))
    else $error("mode not restored after low-voltage reset");

  a_lvr_level: assert property (
    lvr_clr |=> level_result >= SVM_LEVEL_RELEASE)
    else $error("low-voltage reset released below level two");

  a_active_busy: assert property (
    sampling_active == busy)
    else $error("analog enable differs from conversion window");

endmodule : svm_ctrl

// [hdl/svm_pkg.sv]
// constants and types shared by the supply voltage monitor control
package svm_pkg;
  // register index as printed; byte address is four times the index
  localparam logic [15:0] SVM_CTRL_RESULT_IDX = 16'hff12;
  localparam int SVM_ADDR_W = 18;
  localparam logic [17:0] SVM_CTRL_RESULT_ADDR = {SVM_CTRL_RESULT_IDX, 2'b00};

  // field positions inside the control/result byte
  localparam int SVM_AUTO_BIT = 5;
  localparam int SVM_CONT_BIT = 4;
  localparam int SVM_LEVEL_LSB = 0;
  localparam int SVM_LEVEL_W = 4;

  // reset values
  localparam logic SVM_CONT_RST = 1'b0;
  localparam logic SVM_AUTO_RST = 1'b0;
  localparam logic [3:0] SVM_LEVEL_RST = 4'h0;

  // level codes used by the low-voltage reset
  localparam logic [3:0] SVM_LEVEL_ZERO = 4'h0;
  localparam logic [3:0] SVM_LEVEL_RELEASE = 4'h2;
  localparam logic [2:0] SVM_ZERO_RUN = 3'h4;

  // timing
  localparam longint SVM_CLK_HZ = 100_000_000;
  localparam longint SVM_TICK_HZ = 2048;
  localparam int SVM_TICK_CYCLES = int'(SVM_CLK_HZ / SVM_TICK_HZ);
  localparam int SVM_CONV_TICKS = 16;
  localparam int SVM_CONV_TIME_US = 7800;
  localparam int SVM_AUTO_PERIOD_S = 4;
  localparam int SVM_AUTO_TICKS = SVM_AUTO_PERIOD_S * int'(SVM_TICK_HZ);
  localparam logic [3:0] SVM_CONV_LAST = 4'(SVM_CONV_TICKS - 1);

  typedef enum logic [1:0] {
    SVM_ST_IDLE = 2'b01,
    SVM_ST_CONV = 2'b10
  } svm_state_e;
endpackage : svm_pkg

// [testbench/tb_svm_ctrl.sv]
// self-checking bench for the supply voltage monitor control
`timescale 1ns/1ps
module tb_svm_ctrl import svm_pkg::*;;
  localparam int TC = 4;
  localparam int AT = 40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [SVM_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_instruction = 1'b0;
  logic cmp_above = 1'b0;
  logic [3:0] sar_trial;
  logic sampling_active;
  logic osc_stop_grant;
  logic lv_reset;
  logic [3:0] level_result;
  logic [3:0] vlevel = 4'h9;
  logic [31:0] v;
  logic e;
  int fails = 0;
  int n_tests = 0;
  int n, n1, n2;

  svm_ctrl #(.TICK_CYCLES(TC), .AUTO_TICKS(AT), .LVR_OPTION(1'b1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instruction(sleep_instruction), .cmp_above(cmp_above), .sar_trial(sar_trial),
    .sampling_active(sampling_active), .osc_stop_grant(osc_stop_grant),
    .lv_reset(lv_reset), .level_result(level_result));

  always #5 pclk = ~pclk;
  // comparator stand-in: supply sits at vlevel, one cycle of analog lag
  always @(posedge pclk) cmp_above <= (vlevel >= sar_trial);

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fails++;
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd;
    apb(1'b0, SVM_CTRL_RESULT_ADDR, 32'h0);
  endtask : rd

  task automatic wr(input logic [31:0] d);
    apb(1'b1, SVM_CTRL_RESULT_ADDR, d);
  endtask : wr

  // bounded wait on 0 active, 1 low-voltage reset, 2 stop grant
  task automatic wt(input int s, input logic l, output int c);
    logic q;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
      q = (s == 0) ? sampling_active : (s == 1) ? lv_reset : osc_stop_grant;
    end while (q !== l && c < 2000);
    if (c >= 2000) fails++;
  endtask : wt

  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd();
    chk(v[4], 1);
    wt(0, 1, n);
    wt(0, 0, n);
    rd();
    chk(v, 32'h09);
    chk(level_result, 32'h9);
    apb(1'b0, 18'h0, 32'h0);
    chk({v[31:1], e}, 32'h1);
    $display("test reset done");
    vlevel <= 4'h5;
    wr(32'h10);
    wt(0, 1, n);
    rd();
    chk(v[4], 1);
    n = 0;
    // a gap between back-to-back conversions would show as a low cycle
    repeat (150) begin
      @(posedge pclk);
      if (sampling_active !== 1'b1) n++;
    end
    chk(n, 0);
    wr(32'h0);
    rd();
    chk(v[4], 1);
    wt(0, 0, n);
    rd();
    chk(v, 32'h05);
    $display("test continuous done");
    vlevel <= 4'h7;
    wr(32'h30);
    wr(32'h20);
    wt(0, 1, n);
    wt(0, 0, n);
    rd();
    chk(v, 32'h27);
    // the short continuous spell may start an off-interval conversion,
    // so only the span between two auto starts is timed
    wt(0, 1, n);
    wt(0, 0, n1);
    vlevel <= 4'h3;
    wt(0, 1, n2);
    chk(n1 + n2, AT * TC);
    repeat (2) @(posedge pclk);
    rd();
    chk(v, 32'h37);
    wr(32'h0);
    rd();
    chk(v[4], 1);
    wt(0, 0, n);
    rd();
    chk(v, 32'h03);
    $display("test auto done");
    wr(32'h30);
    wt(0, 1, n);
    sleep_instruction <= 1'b1;
    @(posedge pclk);
    sleep_instruction <= 1'b0;
    rd();
    chk(v & 32'h30, 32'h10);
    wt(2, 1, n);
    chk(sampling_active, 0);
    chk(n > 8, 1);
    rd();
    chk(v, 32'h03);
    sleep_instruction <= 1'b1;
    @(posedge pclk);
    sleep_instruction <= 1'b0;
    wt(2, 1, n);
    chk(n < 4, 1);
    $display("test sleep done");
    vlevel <= 4'h0;
    wr(32'h20);
    wt(1, 1, n);
    rd();
    chk(v[4], 1);
    vlevel <= 4'h1;
    repeat (150) @(posedge pclk);
    chk(lv_reset, 1);
    vlevel <= 4'h2;
    wt(1, 0, n);
    rd();
    chk(v & 32'h2f, 32'h22);
    $display("test low voltage done");
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd();
    chk(v & 32'h30, 32'h10);
    $display("test second reset done");
    close_out();
  end
endmodule : tb_svm_ctrl
